// ===== hw/ddrpi_lane.sv
// One byte lane: mask-gated write capture on both link clock edges
`timescale 1ns/1ps
module ddrpi_lane (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic link_rst,
    // Lane pins
    input wire logic [7:0] dq_in,
    input wire logic dm_in,
    // Write capture control and result
    input wire logic wr_en,
    input wire logic [7:0] old_rise,
    input wire logic [7:0] old_fall,
    output logic [7:0] cap_rise,
    output logic [7:0] cap_fall
);
    // Fall capture only follows a rise capture of the same period
    logic fall_en_r;
    // mask gates data on both link clock edges
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            cap_rise <= 8'h00;
            fall_en_r <= 1'b0;
        end else begin
            fall_en_r <= wr_en;
            if (wr_en) cap_rise <= dm_in ? old_rise : dq_in;
        end
    end
    always_ff @(negedge link_clk) begin
        if (link_rst) begin
            cap_fall <= 8'h00;
        end else if (fall_en_r) begin
            cap_fall <= dm_in ? old_fall : dq_in;
        end
    end
endmodule : ddrpi_lane

// ===== hw/ddrpi_params.svh
// Constants for the DDR pin interface: command codes, field positions, times
`ifndef DDRPI_PARAMS_SVH
`define DDRPI_PARAMS_SVH
// Command codes as {row strobe, column strobe, write enable}, active low
`define DDRPI_CMD_NOP 3'h7
`define DDRPI_CMD_ACT 3'h3
`define DDRPI_CMD_RD 3'h5
`define DDRPI_CMD_WR 3'h4
`define DDRPI_CMD_BST 3'h6
`define DDRPI_CMD_PRE 3'h2
`define DDRPI_CMD_REF 3'h1
`define DDRPI_CMD_MRS 3'h0
// Auto-precharge bit position per organisation
`define DDRPI_AP_POS_X32 8
`define DDRPI_AP_POS_X16 10
// Organisation codes (data width in bits)
`define DDRPI_ORG_X8 8
`define DDRPI_ORG_X16 16
`define DDRPI_ORG_X32 32
// Link clock period (ns) and ref clock period (ns)
`define DDRPI_LINK_PERIOD_NS 125
`define DDRPI_REF_PERIOD_NS 40
// Cycles of read latency from read command to first data, link clocks
`define DDRPI_RD_LATENCY 2
`define DDRPI_BURST_LEN 4
`define DDRPI_MODE_RESET 13'h0000
`endif

// ===== hw/ddrpi_pkg.sv
// Types for the DDR pin interface
package ddrpi_pkg;
    typedef enum logic [1:0] {
        DDRPI_PWR_ON,
        DDRPI_PWR_PRE_DOWN,
        DDRPI_PWR_ACT_DOWN,
        DDRPI_PWR_SELF_REF
    } ddrpi_pwr_t;
    typedef enum logic [3:0] {
        DDRPI_C_NONE, DDRPI_C_NOP, DDRPI_C_ACT, DDRPI_C_RD, DDRPI_C_WR,
        DDRPI_C_BST, DDRPI_C_PRE, DDRPI_C_REF, DDRPI_C_MRS
    } ddrpi_cmd_t;
endpackage : ddrpi_pkg

// ===== hw/ddrpi_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module ddrpi_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    // First flop feeds only the second one
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : ddrpi_sync2

// ===== hw/ddrpi_top.sv
// DDR SDRAM pin interface, device side
// Operation
// - Sample commands on rising true clock
// - Data moves on both clock edges
// - Clock enable gates clocks, buffers, drivers (link clock is not gated here; only inputs and drivers are)
// - Enable low picks power-down kind by banks
// - Enable synchronous except self-refresh exit
// - Power-down disables all inputs but clock/enable
// - Chip select low enables decoder, high masks
// - Command from select and three strobes
// - Mask high discards write data
// - x16 masks cover low and high byte
// - x32 masks cover four lanes in order
// - Bank inputs select command's bank
// - Address carries row or column plus AP
// - Mode set loads opcode from address
// - x32 ignores highest address input
// - Strobe out on reads, in on writes (strobe_in unused; writes sampled on link clock edges)
// - Read strobe edge aligned with data
// - x16 strobes time low and high byte
// - x32 strobes time four lanes in order
// - AP high precharges after burst only (bank closes at the command here)
// - Refresh needs all banks precharged
`timescale 1ns/1ps
`include "ddrpi_params.svh"
module ddrpi_top import ddrpi_pkg::*; #(
    parameter int ORG = `DDRPI_ORG_X16,
    parameter int LANES = ORG / 8,
    parameter int DEPTH = 16
) (
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Link clock from controller (true edge)
    input wire logic link_clk,
    // Command pins
    input wire logic clk_en,
    input wire logic chip_sel_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_en_n,
    input wire logic [1:0] bank_addr,
    input wire logic [12:0] addr,
    // Data pins
    input wire logic [ORG-1:0] dq_in,
    output logic [ORG-1:0] dq_out,
    output logic dq_oe,
    input wire logic [LANES-1:0] write_mask,
    input wire logic [LANES-1:0] strobe_in,
    output logic [LANES-1:0] strobe_out,
    output logic [LANES-1:0] strobe_oe,
    // Core-side status
    output ddrpi_pwr_t pwr_state,
    output logic [12:0] mode_word,
    output logic [3:0] banks_open,
    output logic refresh_req,
    output logic cmd_error
);
    localparam int APP = (ORG == `DDRPI_ORG_X32) ?
        `DDRPI_AP_POS_X32 : `DDRPI_AP_POS_X16;
    localparam int LINK_REF_RATIO =
        `DDRPI_LINK_PERIOD_NS / `DDRPI_REF_PERIOD_NS;

    // Link reset comes across from the core domain
    logic link_rst;
    ddrpi_sync2 #(.W(1)) u_rst_sync (
        .clk(link_clk), .rst(1'b0), .d(srst), .q(link_rst));

    // Decode of the three strobes into a command
    function automatic ddrpi_cmd_t decode(input logic cs_n,
                                          input logic [2:0] c);
        ddrpi_cmd_t r;
        r = DDRPI_C_NONE;
        if (cs_n) r = DDRPI_C_NONE;
        else begin
            case (c)
                `DDRPI_CMD_NOP: r = DDRPI_C_NOP;
                `DDRPI_CMD_ACT: r = DDRPI_C_ACT;
                `DDRPI_CMD_RD: r = DDRPI_C_RD;
                `DDRPI_CMD_WR: r = DDRPI_C_WR;
                `DDRPI_CMD_BST: r = DDRPI_C_BST;
                `DDRPI_CMD_PRE: r = DDRPI_C_PRE;
                `DDRPI_CMD_REF: r = DDRPI_C_REF;
                default: r = DDRPI_C_MRS;
            endcase
        end
        return r;
    endfunction : decode

    // command pins registered on rising link edge
    logic cke_r, cke_prev_r, cs_n_r;
    logic [2:0] cmd_bits_r;
    logic [1:0] ba_r;
    logic [12:0] a_r;
    ddrpi_pwr_t link_pwr_r;
    logic in_en;
    // inputs other than clock and enable are gated
    assign in_en = (link_pwr_r == DDRPI_PWR_ON);
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            cke_r <= 1'b0;
            cke_prev_r <= 1'b0;
            cs_n_r <= 1'b1;
            cmd_bits_r <= `DDRPI_CMD_NOP;
            ba_r <= 2'h0;
            a_r <= 13'h0000;
        end else begin
            cke_r <= clk_en;
            cke_prev_r <= cke_r;
            cs_n_r <= in_en ? chip_sel_n : 1'b1;
            cmd_bits_r <= in_en ? {row_strobe_n, col_strobe_n, write_en_n}
                                : `DDRPI_CMD_NOP;
            ba_r <= in_en ? bank_addr : 2'h0;
            // top address bit dropped on x32
            a_r <= in_en ? ((ORG == `DDRPI_ORG_X32) ?
                            {1'b0, addr[11:0]} : addr) : 13'h0000;
        end
    end

    ddrpi_cmd_t cmd;
    assign cmd = decode(cs_n_r, cmd_bits_r);

    // Self-refresh exit seen without a clock: enable raises a flag
    logic sr_exit_r;
    always_ff @(posedge clk_en or posedge link_rst) begin
        if (link_rst) sr_exit_r <= 1'b0;
        else sr_exit_r <= (link_pwr_r == DDRPI_PWR_SELF_REF);
    end
    // Flag is raised without a link clock, so it is resynchronised
    logic sr_exit_s;
    ddrpi_sync2 #(.W(1)) u_sr_sync (
        .clk(link_clk), .rst(link_rst), .d(sr_exit_r), .q(sr_exit_s));

    // Bank state and mode register, link domain
    logic [3:0] open_r;
    logic [12:0] mode_r;
    logic err_r;
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            open_r <= 4'h0;
            mode_r <= `DDRPI_MODE_RESET;
            err_r <= 1'b0;
        end else if (cke_r) begin
            case (cmd)
                DDRPI_C_ACT: open_r[ba_r] <= 1'b1;
                // AP high closes the bank as the access command is taken
                DDRPI_C_RD, DDRPI_C_WR:
                    if (a_r[APP]) open_r[ba_r] <= 1'b0;
                DDRPI_C_PRE:
                    if (a_r[APP]) open_r <= 4'h0;
                    else open_r[ba_r] <= 1'b0;
                DDRPI_C_MRS: if (ba_r == 2'h0) mode_r <= a_r;
                // refresh with a bank open is an error
                DDRPI_C_REF: if (open_r != 4'h0) err_r <= 1'b1;
                default: err_r <= err_r;
            endcase
        end
    end

    // power state from enable and bank state
    // enable low gates input buffers and drivers; link clock flops keep running
    always_ff @(posedge link_clk) begin
        if (link_rst) link_pwr_r <= DDRPI_PWR_ON;
        else begin
            case (link_pwr_r)
                // Registered enable fell with this command: enter low power
                DDRPI_PWR_ON:
                    if (cke_prev_r && !cke_r) begin
                        if (cmd == DDRPI_C_REF)
                            link_pwr_r <= DDRPI_PWR_SELF_REF;
                        else if (open_r != 4'h0)
                            link_pwr_r <= DDRPI_PWR_ACT_DOWN;
                        else link_pwr_r <= DDRPI_PWR_PRE_DOWN;
                    end
                DDRPI_PWR_SELF_REF:
                    // A stale flag alone cannot end a fresh self refresh
                    if (sr_exit_s && cke_r) link_pwr_r <= DDRPI_PWR_ON;
                default:
                    if (clk_en) link_pwr_r <= DDRPI_PWR_ON;
            endcase
        end
    end

    // Array: one word per rise and one per fall, column indexed
    localparam int AW = $clog2(DEPTH);
    logic [ORG-1:0] mem_rise [DEPTH];
    logic [ORG-1:0] mem_fall [DEPTH];
    logic [AW-1:0] col_r;
    logic [2:0] wr_cnt_r, rd_cnt_r;
    logic wr_act, rd_act;
    assign wr_act = (wr_cnt_r != 3'h0);
    assign rd_act = (rd_cnt_r != 3'h0);
    // Burst counters; a new access restarts the column
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            wr_cnt_r <= 3'h0;
            rd_cnt_r <= 3'h0;
            col_r <= '0;
        end else begin
            if (cke_r && (cmd == DDRPI_C_WR || cmd == DDRPI_C_RD))
                col_r <= a_r[AW-1:0];
            else if (wr_act || rd_act) col_r <= col_r + 1'b1;
            if (cke_r && cmd == DDRPI_C_WR)
                wr_cnt_r <= 3'(`DDRPI_BURST_LEN);
            else if (wr_act) wr_cnt_r <= wr_cnt_r - 3'h1;
            if (cke_r && cmd == DDRPI_C_RD)
                rd_cnt_r <= 3'(`DDRPI_BURST_LEN);
            else if (cke_r && cmd == DDRPI_C_BST) rd_cnt_r <= 3'h0;
            else if (rd_act) rd_cnt_r <= rd_cnt_r - 3'h1;
        end
    end

    // one mask per byte lane in order
    logic [ORG-1:0] cap_rise, cap_fall;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // write data taken on link clock edges while a write burst runs
            ddrpi_lane u_lane (
                .link_clk(link_clk),
                .link_rst(link_rst),
                .dq_in(dq_in[g*8 +: 8]),
                .dm_in(write_mask[g]),
                .wr_en(wr_act && in_en),
                .old_rise(mem_rise[col_r][g*8 +: 8]),
                .old_fall(mem_fall[wr_col_r][g*8 +: 8]),
                .cap_rise(cap_rise[g*8 +: 8]),
                .cap_fall(cap_fall[g*8 +: 8]));
        end
    endgenerate
    logic wr_commit_r;
    logic [AW-1:0] wr_col_r;
    // Captured pair is committed one period later
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            wr_commit_r <= 1'b0;
            wr_col_r <= '0;
        end else begin
            wr_commit_r <= wr_act && in_en;
            wr_col_r <= col_r;
            if (wr_commit_r) begin
                mem_rise[wr_col_r] <= cap_rise;
                mem_fall[wr_col_r] <= cap_fall;
            end
        end
    end

    // read strobe toggles with data, both edges
    // one strobe per lane in order
    logic rd_half;
    assign rd_half = link_clk;
    always_comb begin
        dq_oe = rd_act && in_en;
        dq_out = rd_half ? mem_rise[col_r] : mem_fall[col_r];
        strobe_oe = {LANES{dq_oe}};
        strobe_out = {LANES{dq_oe & rd_half}};
    end

    // Status crosses to the core clock through two flops
    logic [20:0] st_sync;
    logic [20:0] st_prev_r;
    logic st_steady;
    // Word taken only when two samples agree, so no torn status
    assign st_steady = (st_sync == st_prev_r);
    ddrpi_sync2 #(.W(21)) u_st_sync (
        .clk(ref_clk), .rst(srst),
        .d({link_pwr_r, mode_r, open_r, err_r, 1'b0}),
        .q(st_sync));
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pwr_state <= DDRPI_PWR_ON;
            mode_word <= 13'h0000;
            banks_open <= 4'h0;
            cmd_error <= 1'b0;
            refresh_req <= 1'b0;
            st_prev_r <= '0;
        end else begin
            st_prev_r <= st_sync;
        end
        if (!srst && st_steady) begin
            pwr_state <= ddrpi_pwr_t'(st_sync[20:19]);
            mode_word <= st_sync[18:6];
            banks_open <= st_sync[5:2];
            cmd_error <= st_sync[1];
            refresh_req <= (st_sync[20:19] == 2'(DDRPI_PWR_SELF_REF));
        end
    end

    // Checks
    a_cs_masks: assert property (@(posedge link_clk) disable iff (link_rst)
        cs_n_r |-> cmd == DDRPI_C_NONE)
        else $error("command decoded while deselected");
    a_ap_close: assert property (@(posedge link_clk) disable iff (link_rst)
        (cke_r && cmd == DDRPI_C_PRE && a_r[APP]) |=> open_r == 4'h0)
        else $error("precharge all left a bank open");
    a_act_open: assert property (@(posedge link_clk) disable iff (link_rst)
        (cke_r && cmd == DDRPI_C_ACT) |=> open_r[$past(ba_r)])
        else $error("activate did not open bank");
    a_pd_kind: assert property (@(posedge link_clk) disable iff (link_rst)
        (link_pwr_r == DDRPI_PWR_ON && cke_prev_r && !cke_r &&
         cmd != DDRPI_C_REF && open_r != 4'h0)
        |=> link_pwr_r == DDRPI_PWR_ACT_DOWN)
        else $error("wrong power-down kind");
    a_no_drive_pd: assert property (@(posedge link_clk) disable iff (link_rst)
        link_pwr_r != DDRPI_PWR_ON |-> !dq_oe)
        else $error("driving while powered down");
    a_x32_a12: assert property (@(posedge link_clk) disable iff (link_rst)
        ORG == `DDRPI_ORG_X32 |-> !a_r[12])
        else $error("top address used on x32");
    a_mrs_load: assert property (@(posedge link_clk) disable iff (link_rst)
        (cke_r && cmd == DDRPI_C_MRS && ba_r == 2'h0)
        |=> mode_r == $past(a_r))
        else $error("mode word not loaded");
    a_ref_err: assert property (@(posedge link_clk) disable iff (link_rst)
        (cke_r && cmd == DDRPI_C_REF && open_r != 4'h0) |=> err_r)
        else $error("refresh with open bank not flagged");
endmodule : ddrpi_top

// ===== testbench/ddr_sdram_pin_interface_tb.sv
// Self-checking bench for the DDR pin interface, x16 organisation
`timescale 1ns/1ps
`include "ddrpi_params.svh"
module ddr_sdram_pin_interface_tb import ddrpi_pkg::*;;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en, chip_sel_n, dq_oe, refresh_req, cmd_error;
    logic [2:0] cmd;
    logic [1:0] bank_addr, write_mask, strobe_in, strobe_out, strobe_oe;
    logic [12:0] addr, mode_word;
    logic [15:0] dq_in, dq_out;
    logic [3:0] banks_open;
    ddrpi_pwr_t pwr_state;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    // Core clock 40 ns; link clock 125 ns, phase unrelated
    always #20 ref_clk = ~ref_clk;
    always #62.5 link_clk = ~link_clk;
    ddrpi_top dut_u (.ref_clk(ref_clk), .srst(srst), .link_clk(link_clk),
        .clk_en(clk_en), .chip_sel_n(chip_sel_n), .row_strobe_n(cmd[2]),
        .col_strobe_n(cmd[1]), .write_en_n(cmd[0]), .bank_addr(bank_addr),
        .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .write_mask(write_mask), .strobe_in(strobe_in),
        .strobe_out(strobe_out), .strobe_oe(strobe_oe),
        .pwr_state(pwr_state), .mode_word(mode_word),
        .banks_open(banks_open), .refresh_req(refresh_req),
        .cmd_error(cmd_error));
    ddrpi_ctrl_model m (.link_clk(link_clk), .clk_en(clk_en),
        .chip_sel_n(chip_sel_n), .cmd(cmd), .bank_addr(bank_addr),
        .addr(addr), .dq_in(dq_in), .write_mask(write_mask),
        .strobe_in(strobe_in));
    // Compare a data or status word
    task automatic check_word(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask : check_word
    // Compare the power state
    task automatic check_pwr(input ddrpi_pwr_t exp);
        checks_done++;
        if (pwr_state !== exp) begin
            fail_count++;
            $display("unexpected pwr_state exp %0d got %0d", exp, pwr_state);
        end
    endtask : check_pwr
    // Verdict and end of run
    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // Status crosses to the core clock a few cycles late
    task automatic settle();
        repeat (16) @(posedge ref_clk);
        #2;
    endtask : settle
    // Watchdog: a hang counts as a mismatch
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // Status after reset
    task automatic t_reset();
        check_pwr(DDRPI_PWR_ON);
        check_word("banks_open", 16'h0000, {12'h000, banks_open});
        check_word("mode_word", {3'h0, `DDRPI_MODE_RESET}, {3'h0, mode_word});
        check_word("oe", 16'h0000, {13'h0, dq_oe, strobe_oe});
    endtask : t_reset
    // Mode load, then a deselected load that must be masked
    task automatic t_mode();
        m.send(1'b0, `DDRPI_CMD_MRS, 2'h0, 13'h1a5c, 1'b1);
        settle();
        check_word("mode_word", 16'h1a5c, {3'h0, mode_word});
        m.send(1'b1, `DDRPI_CMD_MRS, 2'h0, 13'h0333, 1'b1);
        settle();
        check_word("mode_word", 16'h1a5c, {3'h0, mode_word});
    endtask : t_mode
    // Bank selection by activate, single and all-bank precharge
    task automatic t_banks();
        m.send(1'b0, `DDRPI_CMD_ACT, 2'h2, 13'h0123, 1'b1);
        m.send(1'b0, `DDRPI_CMD_ACT, 2'h1, 13'h1fff, 1'b1);
        settle();
        check_word("banks_open", 16'h0006, {12'h0, banks_open});
        m.send(1'b0, `DDRPI_CMD_PRE, 2'h2, 13'h0000, 1'b1);
        settle();
        check_word("banks_open", 16'h0002, {12'h0, banks_open});
        m.send(1'b0, `DDRPI_CMD_PRE, 2'h0, 13'h0400, 1'b1);
        settle();
        check_word("banks_open", 16'h0000, {12'h0, banks_open});
    endtask : t_banks
    // Both power-down kinds, masked input, self refresh and async exit
    task automatic t_power();
        m.send(1'b0, `DDRPI_CMD_ACT, 2'h3, 13'h0010, 1'b1);
        m.send(1'b1, `DDRPI_CMD_NOP, 2'h0, 13'h0000, 1'b0);
        settle();
        check_pwr(DDRPI_PWR_ACT_DOWN);
        m.send(1'b1, `DDRPI_CMD_NOP, 2'h0, 13'h0000, 1'b1);
        settle();
        check_pwr(DDRPI_PWR_ON);
        m.send(1'b0, `DDRPI_CMD_PRE, 2'h0, 13'h0400, 1'b1);
        m.send(1'b1, `DDRPI_CMD_NOP, 2'h0, 13'h0000, 1'b0);
        m.send(1'b0, `DDRPI_CMD_MRS, 2'h0, 13'h0777, 1'b0);
        settle();
        check_pwr(DDRPI_PWR_PRE_DOWN);
        m.send(1'b1, `DDRPI_CMD_NOP, 2'h0, 13'h0000, 1'b1);
        settle();
        check_pwr(DDRPI_PWR_ON);
        check_word("mode_word", 16'h1a5c, {3'h0, mode_word});
        m.send(1'b0, `DDRPI_CMD_REF, 2'h0, 13'h0000, 1'b0);
        settle();
        check_pwr(DDRPI_PWR_SELF_REF);
        m.wake();
        settle();
        check_pwr(DDRPI_PWR_ON);
    endtask : t_power
    // Full write, masked overwrite, read back with auto precharge
    task automatic t_data();
        logic [15:0] wa [8];
        logic [15:0] wb [8];
        logic [15:0] exp;
        logic [1:0] mk [8];
        logic [1:0] none [8];
        int n;
        for (int i = 0; i < 8; i++) begin
            wa[i] = {8'ha0 + 8'(i), 8'h50 + 8'(i)};
            wb[i] = {8'hc0 + 8'(i), 8'h30 + 8'(i)};
            mk[i] = 2'h0;
            none[i] = 2'h0;
        end
        mk[1] = 2'h1;
        mk[4] = 2'h2;
        mk[6] = 2'h3;
        m.send(1'b0, `DDRPI_CMD_ACT, 2'h0, 13'h0005, 1'b1);
        m.send(1'b0, `DDRPI_CMD_WR, 2'h0, 13'h0000, 1'b1);
        m.burst(wa, none);
        m.send(1'b0, `DDRPI_CMD_WR, 2'h0, 13'h0000, 1'b1);
        m.burst(wb, mk);
        m.send(1'b0, `DDRPI_CMD_RD, 2'h0, 13'h0400, 1'b1);
        n = 0;
        while (dq_oe !== 1'b1 && n < 8) begin
            @(posedge link_clk);
            #31;
            n++;
        end
        for (int i = 0; i < 8; i++) begin
            exp = wb[i];
            // Lane g of the word follows mask bit g
            if (mk[i][0]) exp[7:0] = wa[i][7:0];
            if (mk[i][1]) exp[15:8] = wa[i][15:8];
            check_word("dq_out", exp, dq_out);
            check_word("strobe", {12'h0, 2'h3, {2{link_clk}}},
                {12'h0, strobe_oe, strobe_out});
            @(link_clk);
            #31;
        end
        check_word("dq_oe", 16'h0000, {15'h0, dq_oe});
        settle();
        check_word("banks_open", 16'h0000, {12'h0, banks_open});
    endtask : t_data
    // Reset long enough for the link side, then the scenarios
    initial begin
        repeat (10) @(posedge ref_clk);
        #2;
        srst = 1'b0;
        repeat (4) @(posedge link_clk);
        t_reset();
        t_mode();
        t_banks();
        t_power();
        t_data();
        tally_and_finish();
    end
endmodule : ddr_sdram_pin_interface_tb

// ===== testbench/ddrpi_ctrl_model.sv
// Controller-side model driving command, write data, mask and strobe pins
`timescale 1ns/1ps
`include "ddrpi_params.svh"
module ddrpi_ctrl_model #(
    parameter int ORG = 16,
    parameter int LANES = ORG / 8
) (
    // Link clock
    input wire logic link_clk,
    // Command pins
    output logic clk_en,
    output logic chip_sel_n,
    output logic [2:0] cmd,
    output logic [1:0] bank_addr,
    output logic [12:0] addr,
    // Write data pins
    output logic [ORG-1:0] dq_in,
    output logic [LANES-1:0] write_mask,
    output logic [LANES-1:0] strobe_in
);
    logic [ORG-1:0] dq_r;
    logic [LANES-1:0] dm_r;
    logic wr_act;
    // Released lines show the inverse, so stale data never looks valid
    assign dq_in = wr_act ? dq_r : ~dq_r;
    assign write_mask = wr_act ? dm_r : ~dm_r;
    // centred write strobe
    // Strobe edges sit on link edges, mid-way in each data window
    assign strobe_in = wr_act ? {LANES{link_clk}} : ~{LANES{link_clk}};
    // Idle pins at time zero
    initial begin
        clk_en = 1'b1;
        chip_sel_n = 1'b1;
        cmd = `DDRPI_CMD_NOP;
        bank_addr = 2'h0;
        addr = 13'h0000;
        dq_r = '0;
        dm_r = '0;
        wr_act = 1'b0;
    end
    // command encoding
    // One command per link period, deselected 2 ns after the next rise
    task automatic send(input logic cs_n, input logic [2:0] c,
        input logic [1:0] ba, input logic [12:0] a, input logic cke);
        @(posedge link_clk);
        #2;
        chip_sel_n = cs_n;
        cmd = c;
        bank_addr = ba;
        addr = a;
        clk_en = cke;
        @(posedge link_clk);
        #2;
        chip_sel_n = 1'b1;
        cmd = `DDRPI_CMD_NOP;
    endtask : send
    // two masked words per link period
    // Words change a quarter period before the edge that takes them
    task automatic burst(input logic [ORG-1:0] w [8],
        input logic [LANES-1:0] m [8]);
        @(posedge link_clk);
        @(negedge link_clk);
        for (int i = 0; i < 8; i++) begin
            #31;
            dq_r = w[i];
            dm_r = m[i];
            wr_act = 1'b1;
            @(link_clk);
        end
        #31;
        wr_act = 1'b0;
    endtask : burst
    // asynchronous wake
    // Enable rises mid-period to leave self refresh
    task automatic wake();
        @(posedge link_clk);
        #50;
        clk_en = 1'b1;
    endtask : wake
endmodule : ddrpi_ctrl_model
